// >>> logic/spltx_regs.svh
`ifndef SPLTX_REGS_SVH
`define SPLTX_REGS_SVH

// core clock period and unit interval, in their own units
`define SPLTX_CLK_PS      4000
`define SPLTX_UI_NS       32
// clock cycles per unit interval, derived from the two figures above
`define SPLTX_UI_CYC      ((`SPLTX_UI_NS * 1000) / `SPLTX_CLK_PS)
// delay steps per unit interval (1/8 UI each)
`define SPLTX_DLY_STEPS   8
// words per line in the streaming protocols
`define SPLTX_LINE_WORDS  16
// index of the first bit sent for each word width
`define SPLTX_MSB_W10     4'h9
`define SPLTX_MSB_W8      4'h7
// word sent when there is nothing to send
`define SPLTX_FILL_WORD   10'h000

`endif

// >>> logic/spltx_pkg.sv
package spltx_pkg;

    // output protocol selection
    typedef enum logic [1:0] {
        MODE_STREAM_A           = 2'h0,
        FIXED_LINE_STREAM_MODE_B = 2'h1,
        ACTIVE_ONLY_PACKET_MODE = 2'h2
    } spltx_mode_t;

    // one word for each of the four data lanes, plus its flags
    typedef struct packed {
        logic [3:0][9:0] lane;
        logic            blank;
        logic            eol;
    } spltx_word_t;

    // per-lane delay codes in 1/8 UI steps
    typedef struct packed {
        logic [2:0]      clk_code;
        logic [3:0][2:0] lane_code;
    } spltx_dly_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_DATA = 3'h2,
        ST_FILL = 3'h4
    } spltx_st_t;

    // whole state of the transmitter
    typedef struct packed {
        spltx_st_t       st;
        logic [5:0]      ui;
        logic [3:0]      bidx;
        logic [3:0][9:0] sr;
        logic            ck;
        logic [4:0][63:0] hist;
        logic [4:0]      opos;
        logic [4:0]      oneg;
        logic            lk1;
        logic            lk2;
        logic [15:0]     line;
        logic            rdy;
    } spltx_q_t;

endpackage : spltx_pkg

// >>> logic/spltx_top.sv
// Summary of operation
// - output-only port, four differential data lanes and one DDR clock lane.
// - one forwarded clock lane shared by all four data lanes.
// - three selectable protocols, two streaming and one packetized.
// - streaming lines always carry the same number of words.
// - packetized protocol sends active words, each blanking word replaced by a fill word in its slot.
// - serializer takes 8- or 10-bit words and shifts them out.
// - bits alternate, one centred on rising edge, next on falling edge.
// - each word goes most significant bit first.
// - delay loop drives clock lane and every data lane delay.
// - after lock, each lane delays independently in 1/8 UI steps.
// - one UI is one clock half-period, one bit per lane.
`timescale 1ns/1ps
`default_nettype none
`include "spltx_regs.svh"

module spltx_top #(
    parameter int UI_CYC     = `SPLTX_UI_CYC,
    parameter int LINE_WORDS = `SPLTX_LINE_WORDS
) (
    input  wire logic                   clk,
    input  wire logic                   srst,
    input  wire spltx_pkg::spltx_mode_t mode,
    input  wire logic                   wide_words,
    input  wire spltx_pkg::spltx_dly_t  dly,
    input  wire logic                   dll_lock_raw,
    input  wire logic                   in_valid,
    input  wire spltx_pkg::spltx_word_t in_word,
    output var  logic                   in_ready,
    output var  logic                   dll_locked,
    output var  logic                   fwd_clock_lane_pos,
    output var  logic                   fwd_clock_lane_neg,
    output var  logic                   data_lane0_pos,
    output var  logic                   data_lane0_neg,
    output var  logic                   data_lane1_pos,
    output var  logic                   data_lane1_neg,
    output var  logic                   data_lane2_pos,
    output var  logic                   data_lane2_neg,
    output var  logic                   data_lane3_pos,
    output var  logic                   data_lane3_neg
);

    localparam int         STEP      = UI_CYC / `SPLTX_DLY_STEPS;
    localparam int         UI_C      = UI_CYC;
    // rising lane edge shows one cycle after ui passes mid-bit
    localparam int         RISE_C    = UI_CYC / 2 + 1;
    localparam logic [5:0] UI_LAST   = 6'(UI_CYC - 1);
    localparam logic [5:0] UI_MID    = 6'(UI_CYC / 2 - 1);
    localparam logic [5:0] UI_EDGE   = 6'(UI_CYC / 2);
    localparam logic [5:0] STEP6     = 6'(STEP);
    localparam logic [15:0] LINE_LAST = 16'(LINE_WORDS - 1);
    // negative legs idle high so each pair stays complementary in reset
    localparam spltx_pkg::spltx_q_t Q_RST = '{st:      spltx_pkg::ST_IDLE,
                                              oneg:    5'h1F,
                                              default: '0};

    // delay taps need a whole number of cycles per 1/8 UI
    if (UI_CYC % `SPLTX_DLY_STEPS != 0 || UI_CYC < 8 || UI_CYC > 64 ||
        LINE_WORDS < 1 || LINE_WORDS > 65535) begin : g_bad_param
        $error("spltx_top: UI_CYC or LINE_WORDS out of range");
    end

    spltx_pkg::spltx_q_t q;
    spltx_pkg::spltx_q_t d;
    logic [4:0]          raw;
    logic [4:0]          tap;
    logic [4:0][2:0]     code_v;
    logic                ld;
    logic                take;
    logic                send;

    // lane 4 is the clock lane, treated like any data lane for delay
    assign raw    = {q.ck, q.sr[3][9], q.sr[2][9], q.sr[1][9], q.sr[0][9]};
    assign code_v = {dly.clk_code, dly.lane_code};

    // per-lane delay taps; codes only act once the loop is locked
    for (genvar g = 0; g < 5; g++) begin : g_dly
        logic [2:0] code;
        logic [5:0] idx;
        assign code   = q.lk2 ? code_v[g] : 3'h0;
        assign idx    = 6'(({3'h0, code} * STEP6) - 6'h01);
        assign tap[g] = (code == 3'h0) ? raw[g] : q.hist[g][idx];
    end

    // next-state logic for the whole transmitter
    always_comb begin
        d    = q;
        ld   = (q.ui == UI_LAST) && (q.bidx == 4'h0);
        take = q.rdy && in_valid;
        send = 1'b0;
        d.lk1 = dll_lock_raw;
        d.lk2 = q.lk1;
        for (int i = 0; i < 5; i++) begin
            d.hist[i] = {q.hist[i][62:0], raw[i]};
        end
        d.ui = (q.ui == UI_LAST) ? 6'h00 : q.ui + 6'h01;
        // edge mid-bit so each bit is centred on an edge
        if (q.st != spltx_pkg::ST_IDLE && q.ui == UI_MID) begin
            d.ck = ~q.ck;
        end
        if (q.ui == UI_LAST && !ld) begin
            // msb leaves first, one bit per unit interval
            for (int l = 0; l < 4; l++) begin
                d.sr[l] = {q.sr[l][8:0], 1'b0};
            end
            d.bidx = q.bidx - 4'h1;
        end
        if (ld) begin
            case (mode)
                spltx_pkg::ACTIVE_ONLY_PACKET_MODE: begin
                    send = take && !in_word.blank;
                end
                spltx_pkg::MODE_STREAM_A,
                spltx_pkg::FIXED_LINE_STREAM_MODE_B: begin
                    send = take && (q.st != spltx_pkg::ST_FILL);
                end
                default: begin
                    send = 1'b0;
                end
            endcase
            // every lane loads in the same cycle, so boundaries align
            for (int l = 0; l < 4; l++) begin
                if (!send) begin
                    d.sr[l] = `SPLTX_FILL_WORD;
                end else if (wide_words) begin
                    d.sr[l] = in_word.lane[l];
                end else begin
                    d.sr[l] = {in_word.lane[l][7:0], 2'h0};
                end
            end
            d.bidx = wide_words ? `SPLTX_MSB_W10 : `SPLTX_MSB_W8;
            if (mode == spltx_pkg::ACTIVE_ONLY_PACKET_MODE) begin
                d.st   = spltx_pkg::ST_DATA;
                d.line = 16'h0000;
            end else if (q.line == LINE_LAST) begin
                // line closes at a fixed count; pad words fill short lines
                d.line = 16'h0000;
                d.st   = spltx_pkg::ST_DATA;
            end else begin
                d.line = q.line + 16'h0001;
                if (take && in_word.eol && q.st != spltx_pkg::ST_FILL) begin
                    d.st = spltx_pkg::ST_FILL;
                end else if (q.st == spltx_pkg::ST_IDLE) begin
                    d.st = spltx_pkg::ST_DATA;
                end
            end
        end
        // ready stands only in the cycle where a word is loaded
        d.rdy  = (d.ui == UI_LAST) && (d.bidx == 4'h0) &&
                 (d.st != spltx_pkg::ST_FILL);
        d.opos = tap;
        d.oneg = ~tap;
    end

    // single state register
    always_ff @(posedge clk) begin
        if (srst) begin
            q <= Q_RST;
        end else begin
            q <= d;
        end
    end

    assign in_ready           = q.rdy;
    assign dll_locked         = q.lk2;
    assign fwd_clock_lane_pos = q.opos[4];
    assign fwd_clock_lane_neg = q.oneg[4];
    assign data_lane0_pos     = q.opos[0];
    assign data_lane0_neg     = q.oneg[0];
    assign data_lane1_pos     = q.opos[1];
    assign data_lane1_neg     = q.oneg[1];
    assign data_lane2_pos     = q.opos[2];
    assign data_lane2_neg     = q.oneg[2];
    assign data_lane3_pos     = q.opos[3];
    assign data_lane3_neg     = q.oneg[3];

    // clock lane toggles exactly once per unit interval
    a_clk_half_ui: assert property (@(posedge clk) disable iff (srst)
        $changed(q.ck) |-> q.ui == UI_EDGE ##UI_C $changed(q.ck))
        else $error("clock lane half-period is not one UI");

    a_pair_compl: assert property (@(posedge clk) disable iff (srst)
        (q.opos ^ q.oneg) == 5'h1F)
        else $error("differential pair not complementary");

    a_word_rising: assert property (@(posedge clk) disable iff (srst)
        ld && q.st != spltx_pkg::ST_IDLE |-> !q.ck ##RISE_C q.ck)
        else $error("word does not start on a rising clock edge");

    a_msb_first: assert property (@(posedge clk) disable iff (srst)
        ld && send |=> q.sr[0][9] == ($past(wide_words) ?
            $past(in_word.lane[0][9]) : $past(in_word.lane[0][7])))
        else $error("first bit of word is not its msb");

    a_word_width: assert property (@(posedge clk) disable iff (srst)
        ld |=> q.bidx == ($past(wide_words) ? 4'h9 : 4'h7))
        else $error("bit count does not match word width");

    a_pkt_drop: assert property (@(posedge clk) disable iff (srst)
        ld && take && in_word.blank &&
        mode == spltx_pkg::ACTIVE_ONLY_PACKET_MODE |=> q.sr == '0)
        else $error("blanking word sent in packet mode");

    a_line_fixed: assert property (@(posedge clk) disable iff (srst)
        q.line <= LINE_LAST && (q.st != spltx_pkg::ST_FILL || !q.rdy))
        else $error("streaming line length not held");

    a_unlock_zero: assert property (@(posedge clk) disable iff (srst)
        !q.lk2 |=> q.opos[0] == $past(raw[0]) && q.opos[4] == $past(raw[4]))
        else $error("delay applied before lock");

    a_delay_step: assert property (@(posedge clk) disable iff (srst)
        q.lk2 && dly.lane_code[1] == 3'h3 |=>
        q.opos[1] == $past(q.hist[1][3 * STEP - 1]))
        else $error("three-step delay is not 3/8 UI");

endmodule : spltx_top
`default_nettype wire

// >>> tb/spltx_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side receiver: one bit per lane at every forwarded clock edge
module spltx_rx_model (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       ck_pos,
    input  wire logic       ck_neg,
    input  wire logic [3:0] ln_pos,
    input  wire logic [3:0] ln_neg,
    output var  logic       got,
    output var  logic [4:0] bit_q,
    output var  logic       pair_bad
);
    logic ck_q;
    logic run_q;
    // seen from the core clock, data sits mid-bit at each clock edge
    always_ff @(posedge clk) begin
        got <= 1'b0;
        ck_q <= ck_pos;
        if (srst) begin
            run_q <= 1'b0;
            pair_bad <= 1'b0;
        end else begin
            if ({ck_neg, ln_neg} !== ~{ck_pos, ln_pos}) begin
                pair_bad <= 1'b1;
            end
            if (ck_pos !== ck_q && (run_q || ck_pos)) begin
                run_q <= 1'b1;
                got <= 1'b1;
                bit_q <= {ck_pos, ln_pos};
            end
        end
    end
endmodule : spltx_rx_model
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int LW = 4;
    logic                   clk, srst, wide, lock_raw, in_valid, pk;
    spltx_pkg::spltx_mode_t mode;
    spltx_pkg::spltx_dly_t  dly;
    spltx_pkg::spltx_word_t in_word;
    logic                   in_ready, dll_locked, ck_p, ck_n, got, bad;
    logic [3:0]             dp, dn;
    logic [4:0]             rx_bit;
    logic [4:0]             exp_q[$];
    logic [4:0]             rx_q[$];
    int                     pos, cyc, miscompares, tests_run;

    assign pk = (mode == spltx_pkg::ACTIVE_ONLY_PACKET_MODE);
    spltx_top #(.UI_CYC(8), .LINE_WORDS(LW)) dut (
        .clk(clk), .srst(srst), .mode(mode), .wide_words(wide), .dly(dly),
        .dll_lock_raw(lock_raw), .in_valid(in_valid), .in_word(in_word),
        .in_ready(in_ready), .dll_locked(dll_locked),
        .fwd_clock_lane_pos(ck_p), .fwd_clock_lane_neg(ck_n),
        .data_lane0_pos(dp[0]), .data_lane0_neg(dn[0]),
        .data_lane1_pos(dp[1]), .data_lane1_neg(dn[1]),
        .data_lane2_pos(dp[2]), .data_lane2_neg(dn[2]),
        .data_lane3_pos(dp[3]), .data_lane3_neg(dn[3]));
    spltx_rx_model rx (
        .clk(clk), .srst(srst), .ck_pos(ck_p), .ck_neg(ck_n), .ln_pos(dp),
        .ln_neg(dn), .got(got), .bit_q(rx_bit), .pair_bad(bad));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input string nm, input logic [15:0] seen,
                         input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    // expected edge stream, msb first, odd bits on rising edges
    task automatic push_word(input logic [3:0][9:0] w);
        int nb;
        nb = wide ? 10 : 8;
        for (int i = nb - 1; i >= 0; i--) begin
            exp_q.push_back({i[0], w[3][i], w[2][i], w[1][i], w[0][i]});
        end
    endtask : push_word

    // hang guard, generous for a few thousand cycles of traffic
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            miscompares++;
            give_verdict();
        end
    end

    // loads seen at the core clock; padding is owed right after eol
    always @(posedge clk) begin
        if (got === 1'b1) rx_q.push_back(rx_bit);
        if (srst) pos = 0;
        else if (in_ready === 1'b1) begin
            if (!in_valid || (pk && in_word.blank)) push_word('0);
            else push_word(in_word.lane);
            if (pk) pos = 0;
            else if (in_valid && in_word.eol) begin
                repeat (LW - 1 - pos) push_word('0);
                pos = 0;
            end else pos = (pos + 1) % LW;
        end
    end

    function automatic spltx_pkg::spltx_word_t mkw(input logic [9:0] b,
            input logic u, input logic bl, input logic e);
        mkw.blank = bl;
        mkw.eol = e;
        for (int k = 0; k < 4; k++) begin
            mkw.lane[k] = b ^ ({10{u}} & (10'h025 * 10'(k)));
        end
    endfunction : mkw

    // offer a word, hold it to its load edge; n is cycles waited
    task automatic send(input spltx_pkg::spltx_word_t w, output int n);
        in_word = w;
        in_valid = 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (in_ready !== 1'b1 && n < 400);
        if (n >= 400) miscompares++;
        #1;
    endtask : send

    task automatic drain();
        in_valid = 1'b0;
        repeat (120) @(posedge clk);
        #1;
        while (rx_q.size() > 0 && exp_q.size() > 0)
            check("edge", 16'(rx_q.pop_front()), 16'(exp_q.pop_front()));
        check("pair", 16'(bad), 16'h0000);
    endtask : drain

    task automatic t_reset();
        check("idle pos", 16'({ck_p, dp, in_ready, dll_locked}), 16'h0000);
        check("idle neg", 16'({ck_n, dn}), 16'h001F);
        $display("test reset done");
    endtask : t_reset

    // full line back to back, load period is one word of bits
    task automatic t_stream(input spltx_pkg::spltx_mode_t m, input logic w);
        int n;
        mode = m;
        wide = w;
        for (int i = 0; i < LW; i++) begin
            send(mkw(10'h2C9 + 10'(i), 1'b1, i[0], 1'b0), n);
            if (i > 0) check("period", 16'(n), w ? 16'h0050 : 16'h0040);
        end
        drain();
        $display("test stream done");
    endtask : t_stream

    // eol at line position 1 leaves two fill words owed
    task automatic t_eol();
        int n;
        mode = spltx_pkg::FIXED_LINE_STREAM_MODE_B;
        wide = 1'b1;
        do send(mkw(10'h111, 1'b1, 1'b0, 1'b0), n); while (pos != 1);
        send(mkw(10'h3C3, 1'b1, 1'b0, 1'b1), n);
        send(mkw(10'h0F0, 1'b1, 1'b0, 1'b0), n);
        check("pad gap", 16'(n), 16'h00F0);
        drain();
        $display("test eol done");
    endtask : t_eol

    task automatic t_packet();
        int n;
        mode = spltx_pkg::ACTIVE_ONLY_PACKET_MODE;
        send(mkw(10'h2AA, 1'b1, 1'b1, 1'b0), n);
        send(mkw(10'h155, 1'b1, 1'b0, 1'b1), n);
        send(mkw(10'h0CC, 1'b1, 1'b0, 1'b0), n);
        check("no pad", 16'(n), 16'h0050);
        drain();
        $display("test packet done");
    endtask : t_packet

    // lane 1 against lane 0 on equal bits, before and after lock
    task automatic t_delay();
        int n;
        int d;
        dly = '0;
        dly.lane_code[1] = 3'h3;
        for (int s = 0; s < 2; s++) begin
            lock_raw = s[0];
            send(mkw(10'h000, 1'b0, 1'b0, 1'b0), n);
            send(mkw(10'h3FF, 1'b0, 1'b0, 1'b0), n);
            n = 0;
            d = 0;
            while (dp[0] !== 1'b1 && n < 200) begin
                @(posedge clk);
                n++;
            end
            while (dp[1] !== 1'b1 && d < 20) begin
                @(posedge clk);
                d++;
            end
            #1;
            check("skew", 16'(d), s ? 16'h0003 : 16'h0000);
            check("locked", 16'(dll_locked), 16'(s));
        end
        dly = '0;
        drain();
        $display("test delay done");
    endtask : t_delay

    initial begin
        srst = 1'b1;
        in_valid = 1'b0;
        lock_raw = 1'b0;
        wide = 1'b1;
        mode = spltx_pkg::MODE_STREAM_A;
        dly = '0;
        in_word = '0;
        repeat (4) @(posedge clk);
        #1;
        t_reset();
        @(posedge clk);
        #1;
        srst = 1'b0;
        t_stream(spltx_pkg::MODE_STREAM_A, 1'b1);
        t_stream(spltx_pkg::FIXED_LINE_STREAM_MODE_B, 1'b0);
        t_eol();
        t_packet();
        t_delay();
        give_verdict();
    end
endmodule : tb
`default_nettype wire
